// ### core/bhc_supervisor.sv
// Strap latch, hiccup overcurrent protection and soft start with APB registers
`timescale 1ns/1ps
// Functional notes
// - Straps captured once at power-up, held until bias UVLO cycles.
// - Feedback strap: tie=3.3 V, 24.9k=5 V, 49.9k=12 V, else external.
// - Internal compensation only with 10k strap; otherwise external high-gain.
// - Compensation mode latched; no change until bias UVLO.
// - Below min on-time ratio, leave fixed frequency and skip pulses.
// - Current-limit trip ends the high-side pulse at once.
// - Soft-start clamp enabled only after 16 overcurrent events.
// - 512 over-limit cycles allowed before hiccup.
// - Four consecutive clean cycles clear the 512 counter.
// - Expiry: pull soft start low, gates off, start 16384 off count.
// - At 16384 off cycles release soft start and restart.
// - Hiccup inactive during soft start until feedback above 0.4 V.
// - Soft-start ramp about 3 ms, initial or after hiccup.
module bhc_supervisor #(
  parameter int OC_LIMIT = bhc_pkg::OC_LIMIT_CYCLES,
  parameter int OFF_CYCLES = bhc_pkg::HICCUP_OFF_CYCLES,
  parameter int SS_CYC = bhc_pkg::SS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bias_uvlo,
  input wire logic sw_clk,
  input wire logic pwm_demand,
  input wire logic current_limit_trip,
  input wire logic fb_above_0v4,
  input wire logic ratio_below_min,
  input wire logic fb_strap_valid,
  input wire logic [1:0] fb_strap_code,
  input wire logic comp_select_pin,
  output logic high_side_gate,
  output logic low_side_gate,
  output logic ss_pull_low,
  output logic ss_clamp_en,
  output logic [1:0] output_sense_select,
  output logic internal_comp,
  output logic pulse_skip,
  output logic irq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (OC_LIMIT < 2 || OC_LIMIT > 65535 || OFF_CYCLES < 2 || OFF_CYCLES > 65535)
  begin : g_bad_count
    $error("Protection counts out of range");
  end
  if (SS_CYC < 2 || SS_CYC > 16777215)
  begin : g_bad_ss
    $error("Soft-start count out of range");
  end

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  bhc_pkg::bhc_state_e state;
  bhc_pkg::bhc_state_e next_state;
  logic ctrl_enable;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic straps_taken;
  logic [15:0] oc_cnt;
  logic [15:0] off_cnt;
  logic [2:0] clean_cnt;
  logic [4:0] ev_cnt;
  logic [23:0] ss_cnt;
  logic sw_d;
  logic trip_seen;
  logic trip_d;
  logic skip_d;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_ctrl = paddr == bhc_pkg::ADDR_CTRL;
  wire hit_stat = paddr == bhc_pkg::ADDR_STATUS;
  wire hit_irq = paddr == bhc_pkg::ADDR_IRQ_STAT;
  wire hit_mask = paddr == bhc_pkg::ADDR_IRQ_MASK;
  wire hit_cnt = paddr == bhc_pkg::ADDR_OC_COUNT;
  wire mapped = hit_ctrl || hit_stat || hit_irq || hit_mask || hit_cnt;
  // Switching edge, and whether the closing cycle saw a trip
  wire sw_edge = sw_clk && !sw_d;
  wire cycle_over = trip_seen || current_limit_trip;
  wire active = ctrl_enable && !bias_uvlo;
  // Hiccup counting armed only after soft start passes 0.4 V
  wire protect_on = (state == bhc_pkg::BHC_RUN) ||
    (state == bhc_pkg::BHC_SOFT && fb_above_0v4);
  wire oc_expire = protect_on && sw_edge && cycle_over &&
    (oc_cnt == 16'(OC_LIMIT - 1));
  wire off_done = sw_edge && (off_cnt == 16'(OFF_CYCLES - 1));
  wire ss_done = ss_cnt == 24'(SS_CYC - 1);
  wire trip_rise = current_limit_trip && !trip_d;
  wire skip_rise = ratio_below_min && !skip_d;
  wire [3:0] events = {skip_rise,
    trip_rise && active && (ev_cnt == 5'(bhc_pkg::CLAMP_EVENTS - 1)),
    state == bhc_pkg::BHC_HICCUP && off_done, oc_expire};
  wire [3:0] clr = (wr && hit_irq) ? pwdata[3:0] : 4'h0;
  wire [31:0] rd_mux =
    hit_ctrl ? {31'h0, ctrl_enable} :
    hit_stat ? {24'h0, 1'b0, pulse_skip, ss_clamp_en, internal_comp, output_sense_select, state} :
    hit_irq ? {28'h0, irq_stat} :
    hit_mask ? {28'h0, irq_mask} :
    hit_cnt ? {16'h0, oc_cnt} : 32'h0;

  // Next state of the supervisor
  always_comb
  begin
    next_state = state;
    case (state)
      bhc_pkg::BHC_OFF:
        if (active) next_state = bhc_pkg::BHC_SOFT;
      bhc_pkg::BHC_SOFT:
        if (oc_expire) next_state = bhc_pkg::BHC_HICCUP;
        else if (ss_done) next_state = bhc_pkg::BHC_RUN;
      bhc_pkg::BHC_RUN:
        if (oc_expire) next_state = bhc_pkg::BHC_HICCUP;
      bhc_pkg::BHC_HICCUP:
        if (off_done) next_state = bhc_pkg::BHC_SOFT;
      default:
        next_state = bhc_pkg::BHC_OFF;
    endcase
    if (!active) next_state = bhc_pkg::BHC_OFF;
  end

  // ----------------------------------------------------------------
  // APB slave: zero wait states, error on unmapped address
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_enable <= bhc_pkg::CTRL_ENABLE_RST;
      irq_mask <= bhc_pkg::IRQ_MASK_RST;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      if (wr && hit_ctrl) ctrl_enable <= pwdata[bhc_pkg::CTRL_ENABLE_BIT];
      if (wr && hit_mask) irq_mask <= pwdata[3:0];
      prdata <= (psel && !penable && !pwrite) ? rd_mux : prdata;
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end

  // Sticky events: a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat <= 4'h0;
      irq <= 1'b0;
    end
    else
    begin
      irq_stat <= (irq_stat & ~clr) | events;
      irq <= |(((irq_stat & ~clr) | events) & irq_mask);
    end
  end

  // Strap capture once after UVLO release; UVLO re-arms it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      straps_taken <= 1'b0;
      output_sense_select <= bhc_pkg::VSEL_EXT;
      internal_comp <= 1'b0;
    end
    else if (bias_uvlo)
      straps_taken <= 1'b0;
    else if (!straps_taken)
    begin
      straps_taken <= 1'b1;
      internal_comp <= comp_select_pin;
      if (!fb_strap_valid) output_sense_select <= bhc_pkg::VSEL_EXT;
      else if (fb_strap_code == bhc_pkg::STRAP_TIE) output_sense_select <= bhc_pkg::VSEL_3V3;
      else if (fb_strap_code == bhc_pkg::STRAP_R24K9) output_sense_select <= bhc_pkg::VSEL_5V;
      else if (fb_strap_code == bhc_pkg::STRAP_R49K9) output_sense_select <= bhc_pkg::VSEL_12V;
      else output_sense_select <= bhc_pkg::VSEL_EXT;
    end
  end

  // Protection counters on switching edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= bhc_pkg::BHC_OFF;
      sw_d <= 1'b0;
      trip_seen <= 1'b0;
      trip_d <= 1'b0;
      skip_d <= 1'b0;
      oc_cnt <= 16'h0;
      clean_cnt <= 3'h0;
      off_cnt <= 16'h0;
      ev_cnt <= 5'h0;
      ss_clamp_en <= 1'b0;
      ss_cnt <= 24'h0;
    end
    else
    begin
      state <= next_state;
      sw_d <= sw_clk;
      trip_d <= current_limit_trip;
      skip_d <= ratio_below_min;
      trip_seen <= sw_edge ? 1'b0 : cycle_over;
      if (!active)
      begin
        oc_cnt <= 16'h0;
        clean_cnt <= 3'h0;
        off_cnt <= 16'h0;
        ev_cnt <= 5'h0;
        ss_clamp_en <= 1'b0;
        ss_cnt <= 24'h0;
      end
      else
      begin
        // Clamp armed only after enough trips, so short faults can still pull SS low
        if (trip_rise && ev_cnt != 5'(bhc_pkg::CLAMP_EVENTS)) ev_cnt <= ev_cnt + 5'h1;
        if (trip_rise && ev_cnt == 5'(bhc_pkg::CLAMP_EVENTS - 1)) ss_clamp_en <= 1'b1;
        if (state == bhc_pkg::BHC_SOFT && !ss_done) ss_cnt <= ss_cnt + 24'h1;
        if (state != bhc_pkg::BHC_SOFT) ss_cnt <= 24'h0;
        if (state == bhc_pkg::BHC_HICCUP && sw_edge) off_cnt <= off_cnt + 16'h1;
        if (state != bhc_pkg::BHC_HICCUP) off_cnt <= 16'h0;
        if (oc_expire || !protect_on)
        begin
          oc_cnt <= 16'h0;
          clean_cnt <= 3'h0;
        end
        else if (sw_edge && cycle_over)
        begin
          oc_cnt <= oc_cnt + 16'h1;
          clean_cnt <= 3'h0;
        end
        else if (sw_edge)
        begin
          clean_cnt <= (clean_cnt == 3'(bhc_pkg::CLEAN_CYCLES - 1)) ? 3'h0 : clean_cnt + 3'h1;
          if (clean_cnt == 3'(bhc_pkg::CLEAN_CYCLES - 1)) oc_cnt <= 16'h0;
        end
      end
    end
  end

  // Gate drive, soft-start pull and skip mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      high_side_gate <= 1'b0;
      low_side_gate <= 1'b0;
      ss_pull_low <= 1'b1;
      pulse_skip <= 1'b0;
    end
    else
    begin
      pulse_skip <= active && ratio_below_min;
      ss_pull_low <= (next_state == bhc_pkg::BHC_OFF) ||
        (next_state == bhc_pkg::BHC_HICCUP);
      // Trip cuts the high side immediately; hiccup forces both off
      high_side_gate <= (next_state == bhc_pkg::BHC_SOFT || next_state == bhc_pkg::BHC_RUN) &&
        pwm_demand && !current_limit_trip && !(ratio_below_min && !sw_edge);
      low_side_gate <= (next_state == bhc_pkg::BHC_SOFT || next_state == bhc_pkg::BHC_RUN) &&
        !(pwm_demand && !current_limit_trip);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_trip_cuts_high: assert property (@(posedge pclk) disable iff (!presetn)
    current_limit_trip |=> !high_side_gate) else $error("High side on during trip");
  a_hiccup_gates_off: assert property (@(posedge pclk) disable iff (!presetn)
    oc_expire && active |=> !high_side_gate && !low_side_gate && ss_pull_low)
    else $error("Gates not off at hiccup");
  a_hiccup_release: assert property (@(posedge pclk) disable iff (!presetn)
    state == bhc_pkg::BHC_HICCUP && off_done && active |=> state == bhc_pkg::BHC_SOFT)
    else $error("No restart after off count");
  a_no_early_prot: assert property (@(posedge pclk) disable iff (!presetn)
    state == bhc_pkg::BHC_SOFT && !fb_above_0v4 |=> oc_cnt == 16'h0)
    else $error("Counting before 0.4 V");
  a_clean_clears: assert property (@(posedge pclk) disable iff (!presetn)
    active && protect_on && sw_edge && !cycle_over && clean_cnt == 3'h3 |=> oc_cnt == 16'h0)
    else $error("Clean cycles did not clear counter");
  a_clamp_late: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ss_clamp_en) |-> $past(ev_cnt) == 5'hF) else $error("Clamp enabled early");
  a_uvlo_clears: assert property (@(posedge pclk) disable iff (!presetn)
    !active |=> oc_cnt == 16'h0 && !ss_clamp_en && ev_cnt == 5'h0)
    else $error("Counters not cleared");
  a_strap_held: assert property (@(posedge pclk) disable iff (!presetn)
    straps_taken && !bias_uvlo |=> $stable(internal_comp) && $stable(output_sense_select))
    else $error("Strap changed while powered");
  a_skip_follows: assert property (@(posedge pclk) disable iff (!presetn)
    active && ratio_below_min |=> pulse_skip) else $error("Skip mode missing");

  // ----------------------------------------------------------------
  // Named sequences, the checks built from them, and further single-step checks
  // ----------------------------------------------------------------
  // Last allowed over-limit cycle while the controller runs
  sequence s_last_overlimit;
    active && oc_expire;
  endsequence
  // Both gates parked and soft start held low
  sequence s_hiccup_dark;
    !high_side_gate && !low_side_gate && ss_pull_low;
  endsequence
  // Rising trip that completes the clamp count
  sequence s_sixteenth_trip;
    active && trip_rise && ev_cnt == 5'(bhc_pkg::CLAMP_EVENTS - 1);
  endsequence

  a_expire_enters: assert property (@(posedge pclk) disable iff (!presetn)
    s_last_overlimit |=> state == bhc_pkg::BHC_HICCUP ##1 s_hiccup_dark)
    else $error("Expiry did not enter hiccup");
  a_hiccup_parked: assert property (@(posedge pclk) disable iff (!presetn)
    state == bhc_pkg::BHC_HICCUP |-> s_hiccup_dark) else $error("Gates live in hiccup");
  a_clamp_on: assert property (@(posedge pclk) disable iff (!presetn)
    s_sixteenth_trip |=> ss_clamp_en) else $error("Clamp not enabled");
  a_clamp_sticks: assert property (@(posedge pclk) disable iff (!presetn)
    ss_clamp_en && active |=> ss_clamp_en) else $error("Clamp dropped while running");
  a_strap_taken: assert property (@(posedge pclk) disable iff (!presetn)
    !bias_uvlo && !straps_taken |=> straps_taken) else $error("Straps not captured");
  a_skip_gate: assert property (@(posedge pclk) disable iff (!presetn)
    ratio_below_min && !sw_edge |=> !high_side_gate) else $error("High side between skips");
  a_count_gated: assert property (@(posedge pclk) disable iff (!presetn)
    active && protect_on && !sw_edge |=> $stable(oc_cnt)) else $error("Count off switch edge");

endmodule : bhc_supervisor

// ### shared/bhc_pkg.sv
// Shared constants for the buck supervisory and hiccup protection block
package bhc_pkg;

  // ----------------------------------------------------------------
  // Register map (APB byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_OC_COUNT = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int IRQ_HICCUP_BIT = 0;
  localparam int IRQ_RESTART_BIT = 1;
  localparam int IRQ_CLAMP_BIT = 2;
  localparam int IRQ_SKIP_BIT = 3;
  localparam int IRQ_WIDTH = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic CTRL_ENABLE_RST = 1'b0;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  // ----------------------------------------------------------------
  // Output setpoint encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] VSEL_EXT = 2'h0;
  localparam logic [1:0] VSEL_3V3 = 2'h1;
  localparam logic [1:0] VSEL_5V = 2'h2;
  localparam logic [1:0] VSEL_12V = 2'h3;

  // Strap sense codes from the resistor detectors
  localparam logic [1:0] STRAP_TIE = 2'h0;
  localparam logic [1:0] STRAP_R24K9 = 2'h1;
  localparam logic [1:0] STRAP_R49K9 = 2'h2;

  // ----------------------------------------------------------------
  // Protection counts (switching cycles; clamp count in current-limit trip events)
  // ----------------------------------------------------------------
  localparam int OC_LIMIT_CYCLES = 512;
  localparam int CLEAN_CYCLES = 4;
  localparam int HICCUP_OFF_CYCLES = 16384;
  localparam int CLAMP_EVENTS = 16;

  // Soft-start time in microseconds, timed on the 125 MHz clock
  localparam int SS_TIME_US = 3000;
  localparam int CLK_MHZ = 125;
  localparam int SS_CYCLES = SS_TIME_US * CLK_MHZ;

  // Supervisor states
  typedef enum logic [1:0] {
    BHC_OFF = 2'b00,
    BHC_SOFT = 2'b01,
    BHC_RUN = 2'b11,
    BHC_HICCUP = 2'b10
  } bhc_state_e;

endpackage : bhc_pkg

// ### verification/bhc_power_stage.sv
// Behavioural power stage and comparators on the far side of the supervisor
`timescale 1ns/1ps
module bhc_power_stage (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic overload,
  input wire logic fb_ok,
  output logic sw_clk,
  output logic current_limit_trip,
  output logic fb_above_0v4
);
  logic [2:0] div;

  // Oscillator, one switching cycle per eight pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div <= 3'h0;
    else
      div <= div + 3'h1;
  end

  // Trip only in the high phase, so every overloaded cycle gives one fresh event
  assign sw_clk = div[2];
  assign current_limit_trip = overload & div[2];
  assign fb_above_0v4 = fb_ok;
endmodule : bhc_power_stage

// ### verification/testbench.sv
// Self-checking bench for the supervisor with its power stage model
`timescale 1ns/1ps
module testbench;
  localparam int OCL = 8;
  localparam int OFF = 16;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_v;
  logic pready, pslverr, err_v, bias_uvlo = 1'b0, pwm_demand = 1'b0, ratio_below_min = 1'b0;
  logic fb_strap_valid = 1'b0, comp_select_pin = 1'b0, overload = 1'b0, fb_ok = 1'b1;
  logic [1:0] fb_strap_code = 2'h0, output_sense_select, ev;
  logic sw_clk, current_limit_trip, fb_above_0v4, high_side_gate, low_side_gate, trip_q, ec;
  logic ss_pull_low, ss_clamp_en, internal_comp, pulse_skip, irq;
  int num_errors = 0, n_checks = 0, cycles = 0, hic = 0, seed = 32'h0f1efdd5;

  bhc_supervisor #(.OC_LIMIT(OCL), .OFF_CYCLES(OFF), .SS_CYC(20)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .bias_uvlo, .sw_clk, .pwm_demand, .current_limit_trip, .fb_above_0v4, .ratio_below_min,
    .fb_strap_valid, .fb_strap_code, .comp_select_pin, .high_side_gate, .low_side_gate,
    .ss_pull_low, .ss_clamp_en, .output_sense_select, .internal_comp, .pulse_skip, .irq);
  bhc_power_stage i_stage (.pclk, .presetn, .overload, .fb_ok, .sw_clk, .current_limit_trip,
    .fb_above_0v4);

  // --------------------------------------------------------------
  // Clock, timeout and gate watch
  // --------------------------------------------------------------
  always #4 pclk = ~pclk;

  // Timeout also times how long soft start stays pulled low
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    trip_q <= current_limit_trip;
    if (ss_pull_low)
      hic <= hic + 1;
    if (cycles == 20000)
    begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end

  // A trip seen at an edge must have cut the high side; gates stay off while held low
  always @(negedge pclk)
    if (presetn)
      chk({30'h0, trip_q & high_side_gate, ss_pull_low & (high_side_gate | low_side_gate)}, 0);

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; waits for pready, no wait-state count assumed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_v & m, e);
  endtask : rchk

  task automatic wait_state(input logic [1:0] s);
    int k;
    k = 0;
    do
    begin
      apb(1'b0, bhc_pkg::ADDR_STATUS, 32'h0);
      k++;
    end
    while (rd_v[1:0] !== s && k < 60);
    chk({30'h0, rd_v[1:0]}, {30'h0, s});
  endtask : wait_state

  task automatic sw(input int k);
    repeat (k) @(posedge sw_clk);
    @(posedge pclk);
  endtask : sw

  // Setpoint expected from the feedback strap
  function automatic logic [1:0] exp_output_sense(input logic v, input logic [1:0] c);
    if (!v || c == 2'h3)
      return bhc_pkg::VSEL_EXT;
    return (c == bhc_pkg::STRAP_TIE) ? bhc_pkg::VSEL_3V3 :
      (c == bhc_pkg::STRAP_R24K9) ? bhc_pkg::VSEL_5V : bhc_pkg::VSEL_12V;
  endfunction : exp_output_sense

  task automatic finish_test();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({27'h0, ss_pull_low, high_side_gate, low_side_gate, ss_clamp_en, irq}, 32'h10);
    rchk(bhc_pkg::ADDR_CTRL, 32'h1, 32'h0);
    rchk(bhc_pkg::ADDR_IRQ_MASK, 32'hF, 32'h0);
    rchk(bhc_pkg::ADDR_STATUS, 32'h3, 32'h0);
    apb(1'b0, 8'h40 | (8'($random(seed)) & 8'h3C), 32'h0);
    chk({rd_v[30:0], err_v}, 32'h1);
    // Straps recaptured only across a lockout; later pin changes refused
    for (int i = 0; i < 5; i++)
    begin
      bias_uvlo <= 1'b1;
      fb_strap_valid <= (i != 3);
      fb_strap_code <= (i == 4) ? 2'(($random(seed) & 32'h7FFF) % 3) : i[1:0];
      comp_select_pin <= i[0];
      repeat (3) @(posedge pclk);
      bias_uvlo <= 1'b0;
      ev = exp_output_sense(fb_strap_valid, fb_strap_code);
      ec = comp_select_pin;
      repeat (3) @(posedge pclk);
      fb_strap_code <= ~fb_strap_code;
      fb_strap_valid <= ~fb_strap_valid;
      comp_select_pin <= ~comp_select_pin;
      repeat (4) @(posedge pclk);
      chk({30'h0, output_sense_select}, {30'h0, ev});
      chk({31'h0, internal_comp}, {31'h0, ec});
      rchk(bhc_pkg::ADDR_STATUS, 32'h1C, {27'h0, ec, ev, 2'h0});
    end
    // Overload bursts separated by clean cycles never reach hiccup
    pwm_demand <= 1'b1;
    wr_ctrl: apb(1'b1, bhc_pkg::ADDR_CTRL, 32'h1);
    wait_state(2'b11);
    hic = 0;
    overload <= 1'b1;
    sw(OCL - 2);
    overload <= 1'b0;
    sw(6);
    rchk(bhc_pkg::ADDR_OC_COUNT, 32'hFFFF, 32'h0);
    overload <= 1'b1;
    sw(OCL - 2);
    overload <= 1'b0;
    sw(6);
    rchk(bhc_pkg::ADDR_STATUS, 32'h23, 32'h3);
    // Sustained overload enters hiccup
    overload <= 1'b1;
    wait (ss_pull_low === 1'b1);
    @(posedge pclk);
    overload <= 1'b0;
    chk({31'h0, ss_clamp_en}, 32'h1);
    rchk(bhc_pkg::ADDR_STATUS, 32'h3, 32'h2);
    rchk(bhc_pkg::ADDR_IRQ_STAT, 32'hF, 32'h5);
    // Mask bits enable the line; all zero after reset keeps it quiet
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, bhc_pkg::ADDR_IRQ_MASK, 32'hF);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, bhc_pkg::ADDR_IRQ_STAT, 32'h5);
    rchk(bhc_pkg::ADDR_IRQ_STAT, 32'h5, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, bhc_pkg::ADDR_IRQ_MASK, 32'h0);
    // Off time, then soft start again
    wait (ss_pull_low === 1'b0);
    chk({31'h0, hic >= OFF * 8 - 8 && hic <= OFF * 8 + 8}, 32'h1);
    wait_state(2'b11);
    chk({30'h0, high_side_gate, low_side_gate}, 32'h2);
    pwm_demand <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({30'h0, high_side_gate, low_side_gate}, 32'h1);
    pwm_demand <= 1'b1;
    rchk(bhc_pkg::ADDR_IRQ_STAT, 32'h2, 32'h2);
    // Pulse skipping below the minimum ratio
    ratio_below_min <= 1'b1;
    repeat (20) @(posedge pclk);
    chk({31'h0, pulse_skip}, 32'h1);
    rchk(bhc_pkg::ADDR_IRQ_STAT, 32'h8, 32'h8);
    ratio_below_min <= 1'b0;
    // Disable clears the protection state
    apb(1'b1, bhc_pkg::ADDR_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    chk({31'h0, ss_clamp_en}, 32'h0);
    rchk(bhc_pkg::ADDR_OC_COUNT, 32'hFFFF, 32'h0);
    rchk(bhc_pkg::ADDR_STATUS, 32'h3, 32'h0);
    // Overload in soft start with feedback still low must not count
    fb_ok <= 1'b0;
    overload <= 1'b1;
    apb(1'b1, bhc_pkg::ADDR_CTRL, 32'h1);
    repeat (12) @(posedge pclk);
    rchk(bhc_pkg::ADDR_OC_COUNT, 32'hFFFF, 32'h0);
    rchk(bhc_pkg::ADDR_STATUS, 32'h3, 32'h1);
    overload <= 1'b0;
    fb_ok <= 1'b1;
    finish_test();
  end
endmodule : testbench
